// ---- shared/sdpr_defines.svh ----
// Purpose: Constants for the synchronous dual-port RAM
// Assumes: Included by the package and design files
// Notes: Widths are fixed; the small variant masks the top address bit
// How it works
// - 16-bit words, 32K deep, small variant 16K
// - Both ports reach any word concurrently
// - Address, data, controls captured on clock edge
// - Selected only when low-select low, high-select high
// - Deselected port enters standby independently
// - Write lanes whose lane select is low
// - Read drives selected lanes, floats the rest
// - Output enable high floats data, no clock
// - Per-port latency select picks output latency
// - Flow-through registers chip selects once
// - Pipelined passes chip selects through two stages
// - Lane selects registered once in both settings
// - Write completes within one clock cycle
// - Pipelined read data one cycle later
// - Load strobe low loads external address
// - Advance enable low increments, else hold
// - Counter clear low forces address zero
`ifndef SDPR_DEFINES_SVH
`define SDPR_DEFINES_SVH
`define SDPR_ADDR_W 15
`define SDPR_DATA_W 16
`define SDPR_LANE_W 8
`define SDPR_DEPTH 32768
`define SDPR_TOP_BIT 14
`define SDPR_PORTS 2
`define SDPR_UPPER 1
`define SDPR_LOWER 0
`define SDPR_ADDR_ZERO 15'h0000
`define SDPR_ADDR_ONE 15'h0001
`define SDPR_LANES_NONE 2'h0
`define SDPR_LANES_OFF_N 2'h3
`endif

// ---- shared/sdpr_pkg.sv ----
// Purpose: Types and helpers shared by the dual-port RAM files
// Assumes: sdpr_defines.svh is on the include path
// Notes: Control pins of a port travel as one packed struct
`include "sdpr_defines.svh"
`default_nettype none
package sdpr_pkg;
  typedef logic [`SDPR_ADDR_W-1:0] sdpr_addr_t;
  typedef logic [`SDPR_DATA_W-1:0] sdpr_data_t;

  // Synchronous control pins of one port
  typedef struct packed {
    logic select_active_low_n;
    logic select_active_high;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
    logic read_not_write;
    logic output_latency_select;
    logic external_address_load_n;
    logic counter_advance_enable_n;
    logic counter_clear_n;
  } sdpr_ctl_t;

  // Captured state of one port's input registers
  typedef struct packed {
    sdpr_addr_t addr;
    sdpr_data_t wdata;
    logic sel1;
    logic sel2;
    logic upper_n;
    logic lower_n;
    logic rnw1;
    logic rnw2;
    logic pipe;
  } sdpr_stage_t;

  // Port selection from the two chip selects
  function automatic logic sdpr_selected(input logic low_n, input logic high);
    return !low_n && high;
  endfunction : sdpr_selected

  // Active-high lane mask {upper, lower} from the lane selects
  function automatic logic [1:0] sdpr_lanes(input logic upper_n, input logic lower_n);
    return {~upper_n, ~lower_n};
  endfunction : sdpr_lanes
endpackage : sdpr_pkg
`default_nettype wire

// ---- design/sdpr_port_in.sv ----
// Purpose: Input registers and burst address counter of one port
// Assumes: Bus master runs on mclk, so pins need no synchroniser
// Notes: The counter register is also the address the array uses
`timescale 1ns/10ps
`default_nettype none
`include "sdpr_defines.svh"
module sdpr_port_in #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Port pins
  input wire sdpr_pkg::sdpr_ctl_t ctl,
  input wire sdpr_pkg::sdpr_addr_t ext_addr,
  input wire sdpr_pkg::sdpr_data_t wdata,
  // Registered view
  output sdpr_pkg::sdpr_stage_t stage
);
  import sdpr_pkg::*;

  sdpr_stage_t st_d;
  sdpr_stage_t st_q;

  // Next values of all input registers
  always_comb
  begin
    st_d = st_q;
    st_d.wdata = wdata;
    st_d.sel1 = sdpr_selected(ctl.select_active_low_n, ctl.select_active_high);
    st_d.sel2 = st_q.sel1;
    st_d.upper_n = ctl.upper_lane_select_n;
    st_d.lower_n = ctl.lower_lane_select_n;
    st_d.rnw1 = ctl.read_not_write;
    st_d.rnw2 = st_q.rnw1;
    st_d.pipe = ctl.output_latency_select;
    // Counter ignores the chip and lane selects entirely
    if (!ctl.counter_clear_n)
    begin
      st_d.addr = `SDPR_ADDR_ZERO;
    end
    else if (!ctl.external_address_load_n)
    begin
      st_d.addr = ext_addr;
    end
    else if (!ctl.counter_advance_enable_n)
    begin
      st_d.addr = st_q.addr + `SDPR_ADDR_ONE;
    end
    // Small variant has no top address pin, so it wraps at half depth
    if (!LARGE_VARIANT)
    begin
      st_d.addr[`SDPR_TOP_BIT] = 1'b0;
    end
  end

  // Register stage; reset leaves the port deselected
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign stage = st_q;

  // Address masked to the variant, for checking only
  function automatic sdpr_addr_t fit(input sdpr_addr_t a);
    sdpr_addr_t r;
    r = a;
    if (!LARGE_VARIANT)
    begin
      r[`SDPR_TOP_BIT] = 1'b0;
    end
    return fit_done(r);
  endfunction : fit

  function automatic sdpr_addr_t fit_done(input sdpr_addr_t a);
    return a;
  endfunction : fit_done

  counter_clear_a: assert property (@(posedge mclk) disable iff (reset)
    !ctl.counter_clear_n |=> st_q.addr == `SDPR_ADDR_ZERO)
    else $error("counter clear did not zero the address");
  address_load_a: assert property (@(posedge mclk) disable iff (reset)
    ctl.counter_clear_n && !ctl.external_address_load_n |=> st_q.addr == fit($past(ext_addr)))
    else $error("external address not loaded");
  counter_step_a: assert property (@(posedge mclk) disable iff (reset)
    ctl.counter_clear_n && ctl.external_address_load_n && !ctl.counter_advance_enable_n
    |=> st_q.addr == fit($past(st_q.addr) + `SDPR_ADDR_ONE))
    else $error("counter did not advance");
  counter_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ctl.counter_clear_n && ctl.external_address_load_n && ctl.counter_advance_enable_n
    |=> $stable(st_q.addr))
    else $error("held address changed");
endmodule : sdpr_port_in
`default_nettype wire

// ---- design/sdpr_dual_port.sv ----
// Purpose: Two-port synchronous RAM with byte lanes and burst counter
// Assumes: Both bus masters share mclk; controls arrive on that clock
// Notes: Data pins split into in, out and per-lane enable (low drives)
`timescale 1ns/10ps
`default_nettype none
`include "sdpr_defines.svh"
module sdpr_dual_port #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Synchronous control pins, one struct per port
  input wire sdpr_pkg::sdpr_ctl_t [`SDPR_PORTS-1:0] port_ctl,
  // Address and write data per port
  input wire sdpr_pkg::sdpr_addr_t [`SDPR_PORTS-1:0] port_addr,
  input wire sdpr_pkg::sdpr_data_t [`SDPR_PORTS-1:0] port_wdata,
  // Asynchronous output enables, active low
  input wire logic [`SDPR_PORTS-1:0] port_output_enable_n,
  // Read data and per-lane drive enables, {upper, lower}
  output sdpr_pkg::sdpr_data_t [`SDPR_PORTS-1:0] port_rdata,
  output logic [`SDPR_PORTS-1:0][1:0] port_data_oe_n,
  // Low-power standby flag per port
  output logic [`SDPR_PORTS-1:0] port_standby
);
  import sdpr_pkg::*;

  // Shared array; both ports reach every word
  sdpr_data_t mem [`SDPR_DEPTH];

  sdpr_stage_t st [`SDPR_PORTS];
  logic [1:0] wr_lanes [`SDPR_PORTS];
  sdpr_data_t rd_now [`SDPR_PORTS];
  sdpr_data_t rd_pipe_d [`SDPR_PORTS];
  sdpr_data_t rd_pipe_q [`SDPR_PORTS];
  sdpr_data_t out_d [`SDPR_PORTS];
  sdpr_data_t out_q [`SDPR_PORTS];
  logic [1:0] drv_d [`SDPR_PORTS];
  logic [1:0] drv_q [`SDPR_PORTS];
  logic stby_d [`SDPR_PORTS];
  logic stby_q [`SDPR_PORTS];

  // Write into the array one edge after capture, so a write never
  // spans more than one cycle. Same-word writes from both ports are
  // the masters' business; here the higher port index wins.
  always_ff @(posedge mclk)
  begin
    for (int p = 0; p < `SDPR_PORTS; p++)
    begin
      if (wr_lanes[p][`SDPR_UPPER])
      begin
        mem[st[p].addr][`SDPR_DATA_W-1:`SDPR_LANE_W] <=
          st[p].wdata[`SDPR_DATA_W-1:`SDPR_LANE_W];
      end
      if (wr_lanes[p][`SDPR_LOWER])
      begin
        mem[st[p].addr][`SDPR_LANE_W-1:0] <= st[p].wdata[`SDPR_LANE_W-1:0];
      end
    end
  end

  for (genvar p = 0; p < `SDPR_PORTS; p++)
  begin : g_port
    // Each port has its own input registers and counter
    sdpr_port_in #(
      .LARGE_VARIANT(LARGE_VARIANT)
    ) u_in (
      .mclk(mclk),
      .reset(reset),
      .ctl(port_ctl[p]),
      .ext_addr(port_addr[p]),
      .wdata(port_wdata[p]),
      .stage(st[p])
    );

    // Writes follow the single-stage select in both latency settings
    always_comb
    begin
      wr_lanes[p] = `SDPR_LANES_NONE;
      if (st[p].sel1 && !st[p].rnw1)
      begin
        wr_lanes[p] = sdpr_lanes(st[p].upper_n, st[p].lower_n);
      end
      rd_now[p] = mem[st[p].addr];
    end

    // Next output values; pipelined mode reads from the extra stage
    always_comb
    begin
      rd_pipe_d[p] = rd_now[p];
      out_d[p] = rd_now[p];
      drv_d[p] = `SDPR_LANES_NONE;
      stby_d[p] = !st[p].sel1;
      if (st[p].pipe)
      begin
        out_d[p] = rd_pipe_q[p];
        stby_d[p] = !st[p].sel2;
        if (st[p].sel2 && st[p].rnw2)
        begin
          drv_d[p] = sdpr_lanes(st[p].upper_n, st[p].lower_n);
        end
      end
      else if (st[p].sel1 && st[p].rnw1)
      begin
        drv_d[p] = sdpr_lanes(st[p].upper_n, st[p].lower_n);
      end
    end

    // Output registers
    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        rd_pipe_q[p] <= '0;
        out_q[p] <= '0;
        drv_q[p] <= `SDPR_LANES_NONE;
        stby_q[p] <= 1'b1;
      end
      else
      begin
        rd_pipe_q[p] <= rd_pipe_d[p];
        out_q[p] <= out_d[p];
        drv_q[p] <= drv_d[p];
        stby_q[p] <= stby_d[p];
      end
    end

    // Output enable gates the drivers with no clock in the path,
    // the one output that does not come straight from a flop
    assign port_data_oe_n[p] = ~drv_q[p] | {2{port_output_enable_n[p]}};
    assign port_rdata[p] = out_q[p];
    assign port_standby[p] = stby_q[p];

    flow_deselect_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && !st[p].sel1 |=> port_data_oe_n[p] == `SDPR_LANES_OFF_N)
      else $error("deselected port drove data");
    pipe_deselect_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].sel1 ##1 st[p].pipe |=> port_data_oe_n[p] == `SDPR_LANES_OFF_N)
      else $error("pipelined deselect not honoured two cycles on");
    flow_read_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && st[p].sel1 && st[p].rnw1 && !st[p].upper_n
      |=> drv_q[p][`SDPR_UPPER] && out_q[p] == $past(rd_now[p]))
      else $error("flow-through read data wrong");
    lane_float_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && st[p].lower_n |=> !drv_q[p][`SDPR_LOWER])
      else $error("unselected lane driven");
    pipe_latency_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].sel1 && st[p].rnw1 ##1 st[p].pipe |=> out_q[p] == $past(rd_now[p], 2))
      else $error("pipelined data not one cycle later");
    output_float_a: assert property (@(posedge mclk) disable iff (reset)
      port_output_enable_n[p] && drv_q[p] != `SDPR_LANES_NONE
      |-> port_data_oe_n[p] == `SDPR_LANES_OFF_N)
      else $error("output enable did not float data");
    standby_flow_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && !st[p].sel1 |=> port_standby[p])
      else $error("deselected port not in standby");
    lane_write_a: assert property (@(posedge mclk) disable iff (reset)
      wr_lanes[p][`SDPR_LOWER] && !wr_lanes[`SDPR_PORTS-1-p][`SDPR_LOWER]
      |=> mem[$past(st[p].addr)][`SDPR_LANE_W-1:0] == $past(st[p].wdata[`SDPR_LANE_W-1:0]))
      else $error("lower lane write lost");

    // Upper lane and whole-word writes land one edge after capture
    upper_write_a: assert property (@(posedge mclk) disable iff (reset)
      wr_lanes[p][`SDPR_UPPER] && !wr_lanes[`SDPR_PORTS-1-p][`SDPR_UPPER]
      |=> mem[$past(st[p].addr)][`SDPR_DATA_W-1:`SDPR_LANE_W]
        == $past(st[p].wdata[`SDPR_DATA_W-1:`SDPR_LANE_W]))
      else $error("upper lane write lost");
    word_write_a: assert property (@(posedge mclk) disable iff (reset)
      wr_lanes[p] == ~`SDPR_LANES_NONE && wr_lanes[`SDPR_PORTS-1-p] == `SDPR_LANES_NONE
      |=> mem[$past(st[p].addr)] == $past(st[p].wdata))
      else $error("word write not done in one cycle");

    // A deselected port or a read never touches the array
    idle_no_write_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].sel1
      |-> wr_lanes[p] == `SDPR_LANES_NONE)
      else $error("deselected port wrote");
    read_no_write_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].rnw1
      |-> wr_lanes[p] == `SDPR_LANES_NONE)
      else $error("read cycle wrote the array");

    // Standby tracks the effective select in each latency setting
    pipe_standby_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].pipe && !st[p].sel2
      |=> port_standby[p])
      else $error("pipelined deselect not in standby");
    active_port_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && st[p].sel1
      |=> !port_standby[p])
      else $error("selected port left in standby");

    // Drive follows the lanes and the latency setting
    flow_lower_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && st[p].sel1 && st[p].rnw1 && !st[p].lower_n
      |=> drv_q[p][`SDPR_LOWER])
      else $error("flow-through lower lane not driven");
    pipe_upper_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].sel1 && st[p].rnw1 ##1 st[p].pipe && !st[p].upper_n
      |=> drv_q[p][`SDPR_UPPER])
      else $error("pipelined upper lane not driven");
    pipe_lower_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].sel1 && st[p].rnw1 ##1 st[p].pipe && !st[p].lower_n
      |=> drv_q[p][`SDPR_LOWER])
      else $error("pipelined lower lane not driven");
    pipe_lane_float_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].pipe && st[p].upper_n
      |=> !drv_q[p][`SDPR_UPPER])
      else $error("pipelined unselected lane driven");
    flow_write_float_a: assert property (@(posedge mclk) disable iff (reset)
      !st[p].pipe && !st[p].rnw1
      |=> drv_q[p] == `SDPR_LANES_NONE)
      else $error("flow-through write drove data");
    pipe_write_float_a: assert property (@(posedge mclk) disable iff (reset)
      st[p].pipe && !st[p].rnw2
      |=> drv_q[p] == `SDPR_LANES_NONE)
      else $error("pipelined write drove data");

    // Reset leaves the port deselected with its drivers off
    reset_state_a: assert property (@(posedge mclk)
      reset
      |=> port_standby[p] && port_data_oe_n[p] == `SDPR_LANES_OFF_N)
      else $error("port not idle after reset");
  end
endmodule : sdpr_dual_port
`default_nettype wire

// ---- bench/sdpr_host_model.sv ----
// Purpose: Bus master on one port of the dual-port RAM
// Assumes: Runs on mclk like the design; one access at a time
// Notes: Never writes the word the other master writes in that cycle
`timescale 1ns/10ps
`default_nettype none
module sdpr_host_model (
  // Clock
  input wire logic mclk,
  // Pins towards the port
  output var sdpr_pkg::sdpr_ctl_t ctl,
  output var sdpr_pkg::sdpr_addr_t addr,
  output var sdpr_pkg::sdpr_data_t wdata,
  // Pins from the port
  input wire sdpr_pkg::sdpr_data_t rdata,
  input wire logic [1:0] data_oe_n,
  input wire logic standby
);
  import sdpr_pkg::*;

  // Deselected, counter held, lanes and latency kept
  function automatic sdpr_ctl_t idle(input logic [1:0] ln, input logic p);
    return '{1'b1, 1'b0, ln[1], ln[0], 1'b1, p, 1'b1, 1'b1, 1'b1};
  endfunction : idle

  // Quiet start so nothing is captured during reset
  initial
  begin
    ctl = idle(2'h3, 1'b0);
    addr = 15'h0000;
    wdata = 16'h0000;
  end

  // One access: cm 0 load, 1 advance, 2 hold, 3 clear
  task automatic access(input logic rnw, input logic pipe, input logic [1:0] ln,
                        input logic [1:0] cm, input logic sel, input sdpr_addr_t a,
                        input sdpr_data_t d, output sdpr_data_t rd,
                        output logic [1:0] oe1, output logic [1:0] oe, output logic sb);
    @(posedge mclk);
    ctl <= '{!sel, sel, ln[1], ln[0], rnw, pipe, cm != 2'h0, cm != 2'h1, cm != 2'h3};
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    // Lanes and latency stay for the second stage; released lines show the inverse
    ctl <= idle(ln, pipe);
    addr <= ~a;
    wdata <= ~d;
    @(posedge mclk);
    #1;
    oe1 = data_oe_n;
    if (pipe)
    begin
      @(posedge mclk);
      #1;
    end
    rd = rdata;
    oe = data_oe_n;
    sb = standby;
  endtask : access
endmodule : sdpr_host_model
`default_nettype wire

// ---- bench/test_sync_dual_port_ram_port.sv ----
// Purpose: Self-checking bench for the dual-port RAM
// Assumes: Port 0 writes, port 1 reads, both on mclk
// Notes: Async output enable is toggled between edges on purpose
`timescale 1ns/10ps
`default_nettype none
module test_sync_dual_port_ram_port;
  import sdpr_pkg::*;
  logic mclk;
  logic reset;
  logic [1:0] oe_n;
  wire sdpr_ctl_t [1:0] port_ctl;
  wire sdpr_addr_t [1:0] port_addr;
  wire sdpr_data_t [1:0] port_wdata;
  wire sdpr_data_t [1:0] port_rdata;
  wire [1:0][1:0] port_data_oe_n;
  wire [1:0] port_standby;
  int mismatches;
  int cmp_count;
  sdpr_data_t rd;
  logic [1:0] oe1;
  logic [1:0] oe;
  logic sb;

  sdpr_dual_port #(.LARGE_VARIANT(1'b1)) dut_u (.mclk(mclk), .reset(reset),
    .port_ctl(port_ctl), .port_addr(port_addr), .port_wdata(port_wdata),
    .port_output_enable_n(oe_n), .port_rdata(port_rdata),
    .port_data_oe_n(port_data_oe_n), .port_standby(port_standby));
  sdpr_host_model host_u0 (.mclk(mclk), .ctl(port_ctl[0]), .addr(port_addr[0]),
    .wdata(port_wdata[0]), .rdata(port_rdata[0]), .data_oe_n(port_data_oe_n[0]),
    .standby(port_standby[0]));
  sdpr_host_model host_u1 (.mclk(mclk), .ctl(port_ctl[1]), .addr(port_addr[1]),
    .wdata(port_wdata[1]), .rdata(port_rdata[1]), .data_oe_n(port_data_oe_n[1]),
    .standby(port_standby[1]));

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Writes go through port 0 only, so no same-word collision
  task automatic wr(input logic [1:0] ln, input logic [1:0] cm, input logic sel,
                    input sdpr_addr_t a, input sdpr_data_t d);
    host_u0.access(1'b0, 1'b0, ln, cm, sel, a, d, rd, oe1, oe, sb);
  endtask : wr

  task automatic rdp(input logic pipe, input logic [1:0] ln, input logic [1:0] cm,
                     input logic sel, input sdpr_addr_t a);
    host_u1.access(1'b1, pipe, ln, cm, sel, a, 16'h0000, rd, oe1, oe, sb);
  endtask : rdp

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Watchdog: the whole sequence needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    reset = 1'b1;
    oe_n = 2'h0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rdp(1'b0, 2'h0, 2'h0, 1'b0, 15'h0010);
    check("standby", 16'h0001, {15'h0000, sb});
    check("deselected drive", 16'h0003, {14'h0000, oe});
    wr(2'h0, 2'h0, 1'b1, 15'h0010, 16'hA55A);
    check("write drive", 16'h0003, {14'h0000, oe});
    rdp(1'b0, 2'h0, 2'h0, 1'b1, 15'h0010);
    check("flow read", 16'hA55A, rd);
    check("flow drive", 16'h0000, {14'h0000, oe});
    // Drive must drop with no clock edge in between
    #2 oe_n[1] = 1'b1;
    #1 check("async disable", 16'h0003, {14'h0000, port_data_oe_n[1]});
    // Enable held high over whole reads: data still moves, lanes stay off
    rdp(1'b0, 2'h0, 2'h0, 1'b1, 15'h0010);
    check("disabled drive", 16'h0003, {14'h0000, oe});
    check("disabled read", 16'hA55A, rd);
    @(posedge mclk);
    oe_n[1] <= 1'b0;
    wr(2'h1, 2'h0, 1'b1, 15'h0010, 16'h1234);
    wr(2'h3, 2'h0, 1'b1, 15'h0010, 16'hFFFF);
    wr(2'h0, 2'h0, 1'b0, 15'h0010, 16'h0000);
    rdp(1'b0, 2'h2, 2'h0, 1'b1, 15'h0010);
    check("lower lane drive", 16'h0002, {14'h0000, oe});
    check("lower lane data", 16'h005A, rd & 16'h00FF);
    rdp(1'b1, 2'h0, 2'h0, 1'b1, 15'h0010);
    check("pipe early drive", 16'h0003, {14'h0000, oe1});
    check("pipe read", 16'h125A, rd);
    check("pipe drive", 16'h0000, {14'h0000, oe});
    rdp(1'b1, 2'h1, 2'h0, 1'b1, 15'h0010);
    check("pipe lane drive", 16'h0001, {14'h0000, oe});
    rdp(1'b1, 2'h0, 2'h0, 1'b0, 15'h0010);
    check("pipe deselect", 16'h0003, {14'h0000, oe});
    wr(2'h0, 2'h0, 1'b1, 15'h0020, 16'h1111);
    wr(2'h0, 2'h0, 1'b1, 15'h0021, 16'h2222);
    wr(2'h0, 2'h3, 1'b1, 15'h7FFF, 16'h0F0F);
    rdp(1'b0, 2'h0, 2'h0, 1'b1, 15'h0020);
    check("load read", 16'h1111, rd);
    rdp(1'b0, 2'h0, 2'h1, 1'b1, 15'h7FFF);
    check("advance read", 16'h2222, rd);
    rdp(1'b0, 2'h0, 2'h2, 1'b1, 15'h0000);
    check("hold read", 16'h2222, rd);
    rdp(1'b0, 2'h0, 2'h3, 1'b1, 15'h0021);
    check("clear read", 16'h0F0F, rd);
    rdp(1'b0, 2'h0, 2'h0, 1'b0, 15'h0020);
    rdp(1'b0, 2'h0, 2'h2, 1'b1, 15'h7FFF);
    check("deselected load", 16'h1111, rd);
    // Mid-run reset: both ports idle, counters back at zero, array kept
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    #1 check("reset standby", 16'h0003, {14'h0000, port_standby});
    check("reset drive", 16'h000F, {12'h000, port_data_oe_n});
    rdp(1'b0, 2'h0, 2'h2, 1'b1, 15'h7FFF);
    check("reset address read", 16'h0F0F, rd);
    end_of_test();
  end
endmodule : test_sync_dual_port_ram_port
`default_nettype wire
